// ==== hdl/tai_pkg.sv ====
// Shared constants, types and helpers of the serial audio input block
package tai_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int SAMPLE_W = 24;
	localparam int SHIFT_W = 2 * SAMPLE_W;
	localparam int CNT_W = 7;
	localparam int CTRL_W = 6;
	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] CTRL_INDEX = 12'h01b;
	localparam logic [ADDR_W-1:0] LEFT_INDEX = 12'h01c;
	localparam logic [ADDR_W-1:0] RIGHT_INDEX = 12'h01d;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(CTRL_INDEX << 2);
	localparam logic [ADDR_W-1:0] LEFT_ADDR = ADDR_W'(LEFT_INDEX << 2);
	localparam logic [ADDR_W-1:0] RIGHT_ADDR = ADDR_W'(RIGHT_INDEX << 2);
	// Control field layout
	localparam int FMT_LSB = 0;
	localparam int WL_LSB = 2;
	localparam int BCP_BIT = 4;
	localparam int LRP_BIT = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h06;
	typedef enum logic [1:0]
	{
		FMT_RJ = 2'h0,
		FMT_LJ = 2'h1,
		FMT_I2S = 2'h2,
		FMT_DSP = 2'h3
	} tai_fmt_t;
	localparam logic [CNT_W-1:0] WL_BITS_16 = 7'h10;
	localparam logic [CNT_W-1:0] WL_BITS_20 = 7'h14;
	localparam logic [CNT_W-1:0] WL_BITS_24 = 7'h18;
	localparam logic [CNT_W-1:0] CNT_MAX = 7'h7f;
	localparam logic [CNT_W-1:0] RJ_SPAN = 7'h3f;
	localparam logic [CNT_W-1:0] ONE_BIT = 7'h01;
	localparam int SYNC_W = 3;

	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} tai_apb_req_t;

	typedef struct packed
	{
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} tai_apb_rsp_t;

	typedef struct packed
	{
		logic bclk;
		logic lrclk;
		logic data;
	} tai_pins_t;

	typedef struct packed
	{
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
	} tai_sample_t;

	function automatic logic [CNT_W-1:0] wlBits(input logic [1:0] code);
		unique case (code)
			2'h3, 2'h2: return WL_BITS_24;
			2'h1: return WL_BITS_20;
			default: return WL_BITS_16;
		endcase
	endfunction

	function automatic logic [SAMPLE_W-1:0] lowBits(input logic [SHIFT_W-1:0] v,
		input logic [CNT_W-1:0] n);
		logic [SHIFT_W-1:0] m;
		m = ~({SHIFT_W{1'b1}} << n);
		return SAMPLE_W'(v & m);
	endfunction
endpackage

// ==== hdl/tai_pin_sync.sv ====
// Two-stage synchroniser for the serial audio pins
`timescale 1ns/1ns
module tai_pin_sync #(
	parameter int WIDTH = 3
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinSync
);
	typedef struct packed
	{
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} tai_sync_state_t;

	tai_sync_state_t st_reg;
	tai_sync_state_t st_next;

	always_comb
	begin
		st_next = st_reg;
		st_next.stage1 = pinIn;
		st_next.stage2 = st_reg.stage1;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			st_reg <= '0;
		else if (ce)
			st_reg <= st_next;
	end

	assign pinSync = st_reg.stage2;
endmodule

// ==== hdl/tai_audio_rx.sv ====
// Serial audio input port with APB-programmed frame format control
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
//Contract
//[RULE1] Format field: 11 DSP, 10 I2S, 01 left justified, 00 right; reset I2S.
//[RULE2] Word length field: 11/10 give 24 bits, 01 20, 00 16; reset 20.
//[RULE3] Bit 4 set inverts the serial bit clock, master or slave.
//[RULE4] Bit 5 set inverts frame clock polarity in justified and I2S formats.
//[RULE5] In DSP format bit 5 picks variant A (0) or B (1), no inversion.
module tai_audio_rx
	import tai_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire tai_pkg::tai_apb_req_t apbReq,
	output tai_pkg::tai_apb_rsp_t apbRsp,
	input wire tai_pkg::tai_pins_t pinIn,
	output tai_pkg::tai_sample_t sampleOut,
	output logic sampleValid
);
	import tai_pkg::*;

	typedef struct packed
	{
		logic [CTRL_W-1:0] ctrl;
		logic bclkPrev;
		logic lrPrev;
		logic [CNT_W-1:0] bitCount;
		logic [SHIFT_W-1:0] shifter;
		logic [SAMPLE_W-1:0] leftHold;
		tai_sample_t sample;
		logic sampleValid;
		logic [DATA_W-1:0] prdata;
		logic slvErr;
	} tai_state_t;

	tai_state_t st_reg;
	tai_state_t st_next;
	tai_pins_t pinSync;

	// ****************************
	// Pin synchronisers
	// ****************************
	tai_pin_sync #(
		.WIDTH(SYNC_W)
	) pinSyncInst (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ce(ce),
		.pinIn(pinIn),
		.pinSync(pinSync)
	);

	// ****************************
	// Next-state logic
	// ****************************
	always_comb
	begin
		tai_fmt_t fmt;
		logic isDsp;
		logic effBclk;
		logic effLr;
		logic restart;
		logic capture;
		logic [CNT_W-1:0] wl;
		logic [CNT_W-1:0] first;
		logic [CNT_W-1:0] span;
		logic [CNT_W-1:0] idx;
		logic [SHIFT_W-1:0] base;
		logic [SAMPLE_W-1:0] done;
		fmt = tai_fmt_t'(st_reg.ctrl[FMT_LSB +: 2]); // RULE1
		isDsp = (fmt == FMT_DSP);
		wl = wlBits(st_reg.ctrl[WL_LSB +: 2]); // RULE2
		effBclk = pinSync.bclk ^ st_reg.ctrl[BCP_BIT]; // RULE3
		effLr = pinSync.lrclk ^ (st_reg.ctrl[LRP_BIT] & ~isDsp); // RULE4
		first = '0;
		span = wl;
		restart = 1'b0;
		capture = 1'b0;
		idx = '0;
		base = '0;
		done = '0;
		st_next = st_reg;
		st_next.sampleValid = 1'b0;
		st_next.bclkPrev = effBclk;

		unique case (fmt)
			FMT_DSP:
			begin
				// Variant B: data starts on the frame pulse edge
				first = st_reg.ctrl[LRP_BIT] ? '0 : ONE_BIT; // RULE5
				span = CNT_W'(wl << 1);
			end
			FMT_I2S:
				first = ONE_BIT;
			FMT_RJ:
				span = RJ_SPAN;
			FMT_LJ:
				span = wl;
		endcase

		// Bit clock rising edge in the selected sense
		if (effBclk && !st_reg.bclkPrev)
		begin
			st_next.lrPrev = effLr;
			restart = isDsp ? (effLr && !st_reg.lrPrev) : (effLr != st_reg.lrPrev);
			idx = restart ? '0 : st_reg.bitCount;
			base = restart ? '0 : st_reg.shifter;
			capture = (idx >= first) && (idx < CNT_W'(first + span));
			st_next.shifter = capture ? {base[SHIFT_W-2:0], pinSync.data} : base;
			st_next.bitCount = (idx == CNT_MAX) ? idx : CNT_W'(idx + ONE_BIT);
			if (isDsp)
			begin
				// Left then right packed back to back after the pulse
				if (capture && idx == CNT_W'(first + span - ONE_BIT)) // RULE5
				begin
					st_next.sample.left = lowBits(st_next.shifter >> wl, wl);
					st_next.sample.right = lowBits(st_next.shifter, wl);
					st_next.sampleValid = 1'b1;
				end
			end
			else if (restart)
			begin
				// Previous half-frame closes on the frame clock change
				done = lowBits(st_reg.shifter, wl); // RULE2
				if ((fmt == FMT_I2S) ? !st_reg.lrPrev : st_reg.lrPrev) // RULE4
					st_next.leftHold = done;
				else
				begin
					st_next.sample.left = st_reg.leftHold;
					st_next.sample.right = done;
					st_next.sampleValid = 1'b1;
				end
			end
		end

		// APB setup phase prepares the read answer
		if (apbReq.psel && !apbReq.penable)
		begin
			st_next.slvErr = 1'b0;
			unique case (apbReq.paddr)
				CTRL_ADDR:
					st_next.prdata = DATA_W'(st_reg.ctrl);
				LEFT_ADDR:
					st_next.prdata = DATA_W'(st_reg.sample.left);
				RIGHT_ADDR:
					st_next.prdata = DATA_W'(st_reg.sample.right);
				default:
				begin
					st_next.prdata = '0;
					st_next.slvErr = 1'b1;
				end
			endcase
		end

		// Write lands at the access edge
		if (apbReq.psel && apbReq.penable && apbReq.pwrite && apbReq.paddr == CTRL_ADDR)
			st_next.ctrl = apbReq.pwdata[CTRL_W-1:0]; // RULE1
	end

	// ****************************
	// State register
	// ****************************
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_reg <= '0;
			st_reg.ctrl <= CTRL_RESET; // RULE1
		end
		else if (ce)
			st_reg <= st_next;
	end

	// ****************************
	// Outputs
	// ****************************
	assign apbRsp.prdata = st_reg.prdata;
	assign apbRsp.pready = 1'b1;
	assign apbRsp.pslverr = st_reg.slvErr && apbReq.psel && apbReq.penable;
	assign sampleOut = st_reg.sample;
	assign sampleValid = st_reg.sampleValid;
endmodule

// ==== testbench/tai_src.sv ====
// Model of the external processor sending serial audio frames
`timescale 1ns/1ns
module tai_src
	import tai_pkg::*;
(
	input wire logic ref_clk,
	output tai_pkg::tai_pins_t pins
);
	logic inv = 1'b0;
	// High from the bit that closes the frame, so the bench counts only that pulse
	logic tail = 1'b0;
	initial pins = '0;
	task automatic bitOut(input logic lr, input logic d);
		pins.bclk <= inv;
		pins.lrclk <= lr;
		pins.data <= d;
		repeat (4) @(posedge ref_clk);
		pins.bclk <= ~inv;
		repeat (4) @(posedge ref_clk);
	endtask
	// Half word, padded with ones
	function automatic logic [31:0] half(input logic [1:0] f, input int n, input logic [23:0] x);
		logic [31:0] o;
		o = '1;
		case (f)
			FMT_RJ: return (32'(x) & ~(o << n)) | (o << n);
			FMT_LJ: return (32'(x) << (32 - n)) | ~(o << (32 - n));
			default: return (32'(x) << (31 - n)) | ~(o << (31 - n)) | 32'h80000000;
		endcase
	endfunction
	task automatic send(input logic [5:0] c, input logic [23:0] l, input logic [23:0] r);
		logic [63:0] s;
		logic lp;
		int n;
		tail = 1'b0;
		n = c[3] ? 24 : c[2] ? 20 : 16;
		inv = c[4];
		lp = (c[1:0] != FMT_I2S) ^ c[5];
		s = {half(c[1:0], n, l), half(c[1:0], n, r)};
		if (c[1:0] == FMT_DSP)
		begin
			bitOut(1'b0, ~pins.data);
			if (!c[5]) bitOut(1'b1, ~pins.data);
			for (int i = 0; i < 2 * n; i++)
			begin
				tail = (i == 2 * n - 1);
				bitOut(c[5] && i == 0, i < n ? l[n - 1 - i] : r[2 * n - 1 - i]);
			end
		end
		else
		begin
			bitOut(~lp, ~pins.data);
			for (int i = 0; i < 64; i++)
				bitOut(i < 32 ? lp : ~lp, s[63 - i]);
			tail = 1'b1;
			bitOut(lp, ~pins.data);
		end
	endtask
endmodule

// ==== testbench/tai_chk_asserts.sv ====
// Assertions on the ports of the audio input block
`timescale 1ns/1ns
module tai_chk
	import tai_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire tai_pkg::tai_apb_req_t apbReq,
	input wire tai_pkg::tai_apb_rsp_t apbRsp,
	input wire logic sampleValid
);
	logic [5:0] shReg;
	wire acc = apbReq.psel & apbReq.penable & apbReq.paddr == CTRL_ADDR;
	wire rdc = acc & !apbReq.pwrite;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
			shReg <= CTRL_RESET;
		else if (acc & apbReq.pwrite)
			shReg <= apbReq.pwdata[5:0];
	a_fmt_read: assert property (rdc |-> apbRsp.prdata[1:0] == shReg[1:0])
		else $error("format");
	a_wlen_read: assert property (rdc |-> apbRsp.prdata[3:2] == shReg[3:2])
		else $error("length");
	a_bclk_inv: assert property (rdc |-> apbRsp.prdata[4] == shReg[4])
		else $error("invert");
	a_lr_bit: assert property (rdc |-> apbRsp.prdata[5] == shReg[5])
		else $error("frame bit");
	a_valid_pulse: assert property (sampleValid |=> !sampleValid)
		else $error("pulse");
	cover property (sampleValid);
	cover property (rdc);
	cover property (apbRsp.pslverr);
endmodule
bind tai_audio_rx tai_chk tai_chk_inst(.ref_clk(ref_clk), .rstn(rstn), .apbReq(apbReq),
	.apbRsp(apbRsp), .sampleValid(sampleValid));

// ==== testbench/tb_top.sv ====
// Self-checking bench of the serial audio input block
`timescale 1ns/1ns
module tb_top;
	import tai_pkg::*;
	logic ref_clk = 0;
	logic rstn = 0;
	logic ce = 1;
	tai_apb_req_t apbReq = '0;
	tai_apb_rsp_t apbRsp;
	tai_pins_t pinIn;
	tai_sample_t sampleOut, seen;
	logic sampleValid;
	int failures = 0, cmpCount = 0, got = 0;
	logic [31:0] q;
	logic e;
	always #20 ref_clk = ~ref_clk;
	tai_audio_rx tai_audio_rx_inst(.ref_clk, .rstn, .ce, .apbReq, .apbRsp, .pinIn,
		.sampleOut, .sampleValid);
	tai_src tai_src_inst(.ref_clk, .pins(pinIn));
	always @(posedge ref_clk)
		if (sampleValid === 1'b1 && tai_src_inst.tail === 1'b1)
		begin
			got <= got + 1;
			seen <= sampleOut;
		end
	task automatic chk(input logic [47:0] s, input logic [47:0] x);
		cmpCount++;
		if (s !== x)
		begin
			failures++;
			$display("unexpected at %0t: %h not %h", $time, s, x);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge ref_clk);
		apbReq.penable <= 1'b1;
		do @(posedge ref_clk); while (apbRsp.pready !== 1'b1);
		q = apbRsp.prdata;
		e = apbRsp.pslverr;
		apbReq <= '0;
		@(posedge ref_clk);
	endtask
	task automatic t_reset;
		xfer(0, CTRL_ADDR, 0);
		chk(q, CTRL_RESET);
		xfer(1, 12'h004, 32'h3f);
		chk(e, 1);
	endtask
	task automatic t_frames;
		logic [5:0] cf [9] = '{6'h06, 6'h00, 6'h15, 6'h2b, 6'h3e, 6'h33, 6'h0f, 6'h29, 6'h24};
		logic [23:0] l, r, m;
		int g;
		foreach (cf[i])
		begin
			l = 24'hc5a39e ^ 24'(i);
			r = 24'h3b6d71 + 24'(i);
			m = ~(24'hffffff << (cf[i][3] ? 24 : cf[i][2] ? 20 : 16));
			xfer(1, CTRL_ADDR, 32'(cf[i]));
			xfer(0, CTRL_ADDR, 0);
			chk(q, cf[i]);
			g = got;
			tai_src_inst.send(cf[i], l, r);
			for (int k = 0; k < 20 && got == g; k++) @(posedge ref_clk);
			chk(got, g + 1);
			chk(seen, {l & m, r & m});
			xfer(0, LEFT_ADDR, 0);
			chk(q, 48'(l & m));
			xfer(0, RIGHT_ADDR, 0);
			chk(q, 48'(r & m));
		end
	endtask
	task automatic print_verdict;
		$display("failures %0d compares %0d", failures, cmpCount);
		if (failures == 0 && cmpCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		t_reset;
		t_frames;
		print_verdict;
	end
	initial
	begin
		#1000000;
		failures++;
		print_verdict;
	end
endmodule
